// >>> src/pcw_defines.vh
// Address map, field positions and reset value of the PWM cycle configuration block
`ifndef PCW_DEFINES_VH
`define PCW_DEFINES_VH

// ----------------------------------------
// Register addresses and pages
// ----------------------------------------
`define PCW_CFG_ADDR 8'hD9
`define PCW_CFG_PAGE 8'h0F
`define PCW_CMP_PAGE 8'h00
`define PCW_CMP_LO_BASE 8'hE9
`define PCW_CMP_HI_BASE 8'hF9

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define PCW_BIT_RELOAD_SEL 7
`define PCW_BIT_IRQ_EN 6
`define PCW_BIT_OVF_FLAG 5
`define PCW_CLSEL_MSB 1
`define PCW_CLSEL_LSB 0
`define PCW_CFG_RESET 8'h00

// ----------------------------------------
// Cycle length codes and field masks
// ----------------------------------------
`define PCW_LEN_8 2'h0
`define PCW_LEN_9 2'h1
`define PCW_LEN_10 2'h2
`define PCW_LEN_11 2'h3
`define PCW_MASK_8 16'h00FF
`define PCW_MASK_9 16'h01FF
`define PCW_MASK_10 16'h03FF
`define PCW_MASK_11 16'h07FF
`define PCW_MASK_16 16'hFFFF

`endif

// >>> src/pcw_reload_mem.v
// Byte-wide store of the per-module auto-reload values
module pcw_reload_mem #(
    parameter DEPTH = 12,
    parameter AW = 4
) (
    input wire mclk,
    input wire reset,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [7:0] rd_data,
    output wire [8*DEPTH-1:0] all_data
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= 8'h00;
            end
            rd_data <= 8'h00;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            if (rd_en) begin
                rd_data <= mem[rd_addr];
            end
        end
    end

    // ----------------------------------------
    // Parallel view for reload copies
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_flat
            assign all_data[8*g+7:8*g] = mem[g];
        end
    endgenerate

endmodule

// >>> src/pcw_top.v
// PWM cycle length configuration, cycle overflow flag and per-module PWM outputs
`include "pcw_defines.vh"

//Behaviour
// R01 - Bit 7 steers compare addresses to reloads
// R02 - Reload value feeds 9/10/11-bit PWM
// R03 - Reloads inert in other modes, still accessible
// R04 - Bit 6 gates overflow flag onto interrupt
// R05 - Flag set on selected counter bit overflow
// R06 - Flag set by hardware or software one
// R07 - Bits 4:2 read zero, writes ignored
// R08 - Bits 1:0 choose 8 to 11 bits
// R09 - Selected length shared by all narrow PWMs
// R10 - Wide PWM ignores length, uses 16 bits
// R11 - Decodes at 0xD9 page 0x0F, resets zero
// R12 - Per-module select: wide or narrow PWM
// R13 - Enabled PWM drives module output pin
// R14 - Reload copied to compare at overflow
module pcw_top #(
    parameter NUM_MODULES = 6
) (
    input wire mclk,
    input wire reset,
    input wire [7:0] sfr_page,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    output reg sfr_rvalid,
    input wire [15:0] array_main_counter,
    input wire [NUM_MODULES-1:0] pwm_mode_enable,
    input wire [NUM_MODULES-1:0] wide_pwm_select,
    output reg [NUM_MODULES-1:0] module_output_pin,
    output reg cycle_overflow_irq
);

    localparam DEPTH = 2 * NUM_MODULES;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function [3:0] pcw_cmp_hit;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] d;
        begin
            d = addr - base;
            if (d < NUM_MODULES) begin
                pcw_cmp_hit = {1'b1, d[2:0]};
            end else begin
                pcw_cmp_hit = 4'h0;
            end
        end
    endfunction

    function [15:0] pcw_len_mask;
        input [1:0] sel;
        begin
            case (sel)
                `PCW_LEN_8: pcw_len_mask = `PCW_MASK_8;
                `PCW_LEN_9: pcw_len_mask = `PCW_MASK_9;
                `PCW_LEN_10: pcw_len_mask = `PCW_MASK_10;
                `PCW_LEN_11: pcw_len_mask = `PCW_MASK_11;
                default: pcw_len_mask = `PCW_MASK_8;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Configuration register state
    // ----------------------------------------
    reg reload_bank_select;
    reg cycle_overflow_irq_enable;
    reg cycle_overflow_flag;
    reg [1:0] cycle_length_select;
    reg [15:0] counter_prev;

    wire cfg_hit;
    wire cmp_page_ok;
    wire [3:0] lo_hit;
    wire [3:0] hi_hit;
    wire cmp_hit;
    wire [2:0] cmp_idx;
    wire cmp_is_high;
    wire [15:0] len_mask;
    wire cycle_overflow;
    wire next_flag;

    assign cfg_hit = (sfr_addr == `PCW_CFG_ADDR) && (sfr_page == `PCW_CFG_PAGE); // see R11
    assign cmp_page_ok = (sfr_page == `PCW_CMP_PAGE);
    assign lo_hit = pcw_cmp_hit(sfr_addr, `PCW_CMP_LO_BASE);
    assign hi_hit = pcw_cmp_hit(sfr_addr, `PCW_CMP_HI_BASE);
    assign cmp_hit = cmp_page_ok && (lo_hit[3] || hi_hit[3]);
    assign cmp_is_high = hi_hit[3];
    assign cmp_idx = hi_hit[3] ? hi_hit[2:0] : lo_hit[2:0];

    // ----------------------------------------
    // Access strobes
    // ----------------------------------------
    wire cfg_write;
    wire cfg_read;
    wire cmp_write;
    wire cmp_read;

    assign cfg_write = sfr_wr && cfg_hit; // see R11
    assign cfg_read = sfr_rd && cfg_hit; // see R11
    assign cmp_write = sfr_wr && cmp_hit;
    assign cmp_read = sfr_rd && cmp_hit;

    // ----------------------------------------
    // Cycle overflow detection
    // ----------------------------------------
    wire [15:0] prev_field;
    wire [15:0] cur_field;

    assign len_mask = pcw_len_mask(cycle_length_select); // see R08
    assign prev_field = counter_prev & len_mask;
    assign cur_field = array_main_counter & len_mask;
    assign cycle_overflow = (prev_field == len_mask) && (cur_field == 16'h0000); // see R05

    // Hardware set wins over a software clear in the same cycle
    assign next_flag = cycle_overflow ||
                       (cfg_write ? sfr_wdata[`PCW_BIT_OVF_FLAG] : cycle_overflow_flag); // see R06

    // ----------------------------------------
    // Configuration next values
    // ----------------------------------------
    reg next_reload_bank_select;
    reg next_irq_enable;
    reg [1:0] next_length_select;

    always @* begin
        next_reload_bank_select = reload_bank_select;
        next_irq_enable = cycle_overflow_irq_enable;
        next_length_select = cycle_length_select;
        if (cfg_write) begin
            // Bits 4:2 have no storage
            next_reload_bank_select = sfr_wdata[`PCW_BIT_RELOAD_SEL]; // see R07
            next_irq_enable = sfr_wdata[`PCW_BIT_IRQ_EN];
            next_length_select = sfr_wdata[`PCW_CLSEL_MSB:`PCW_CLSEL_LSB];
        end
    end

    // ----------------------------------------
    // Interrupt request
    // ----------------------------------------
    wire next_irq;

    assign next_irq = next_flag && next_irq_enable; // see R04

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reload_bank_select <= 1'b0; // see R11
            cycle_overflow_irq_enable <= 1'b0;
            cycle_overflow_flag <= 1'b0;
            cycle_length_select <= 2'h0;
            counter_prev <= 16'h0000;
            cycle_overflow_irq <= 1'b0;
        end else begin
            counter_prev <= array_main_counter;
            cycle_overflow_flag <= next_flag; // see R06
            reload_bank_select <= next_reload_bank_select;
            cycle_overflow_irq_enable <= next_irq_enable;
            cycle_length_select <= next_length_select;
            cycle_overflow_irq <= next_irq; // see R04
        end
    end

    // ----------------------------------------
    // Auto-reload storage
    // ----------------------------------------
    wire rl_wr;
    wire rl_rd;
    wire [3:0] rl_addr;
    wire [7:0] rl_rdata;
    wire [8*DEPTH-1:0] rl_all;

    assign rl_wr = sfr_wr && cmp_hit && reload_bank_select; // see R01
    assign rl_rd = sfr_rd && cmp_hit && reload_bank_select; // see R03
    assign rl_addr = {cmp_idx, cmp_is_high};

    pcw_reload_mem #(
        .DEPTH(DEPTH),
        .AW(4)
    ) u_reload (
        .mclk(mclk),
        .reset(reset),
        .wr_en(rl_wr),
        .wr_addr(rl_addr),
        .wr_data(sfr_wdata),
        .rd_en(rl_rd),
        .rd_addr(rl_addr),
        .rd_data(rl_rdata),
        .all_data(rl_all)
    );

    // ----------------------------------------
    // Per-module compare values and PWM outputs
    // ----------------------------------------
    wire [16*NUM_MODULES-1:0] cmp_flat;
    wire narrow_reload;

    assign narrow_reload = cycle_overflow && (cycle_length_select != `PCW_LEN_8); // see R02 R03

    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g = g + 1) begin : g_mod
            reg [15:0] module_compare_value;
            reg [15:0] next_compare;
            wire sel_me;
            wire narrow_pwm;
            wire [15:0] mask_me;
            wire [15:0] reload_word;
            wire level;
            wire next_pin;

            assign sel_me = cmp_write && !reload_bank_select && (cmp_idx == g); // see R01
            assign narrow_pwm = pwm_mode_enable[g] && !wide_pwm_select[g]; // see R12
            assign mask_me = wide_pwm_select[g] ? `PCW_MASK_16 : len_mask; // see R09 R10
            assign reload_word = rl_all[16*g+15:16*g];
            assign level = (array_main_counter & mask_me) >= (module_compare_value & mask_me);
            assign next_pin = pwm_mode_enable[g] && level; // see R13
            assign cmp_flat[16*g+15:16*g] = module_compare_value;

            always @* begin
                next_compare = module_compare_value;
                if (sel_me && cmp_is_high) begin
                    next_compare[15:8] = sfr_wdata;
                end else if (sel_me) begin
                    next_compare[7:0] = sfr_wdata;
                end else if (narrow_reload && narrow_pwm) begin
                    next_compare = reload_word; // see R14 R02
                end
            end

            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    module_compare_value <= 16'h0000;
                    module_output_pin[g] <= 1'b0;
                end else begin
                    module_compare_value <= next_compare;
                    module_output_pin[g] <= next_pin;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Register read path
    // ----------------------------------------
    reg rd_stage;
    reg rd_from_mem;
    reg [7:0] rd_local;
    reg [7:0] next_rd_local;
    reg [7:0] next_rdata;
    wire [15:0] cmp_sel;
    wire [7:0] cfg_image;

    assign cmp_sel = cmp_flat[16*cmp_idx +: 16];
    assign cfg_image = {reload_bank_select, cycle_overflow_irq_enable, cycle_overflow_flag,
                        3'h0, cycle_length_select}; // see R07

    // Snapshot at the read edge
    always @* begin
        next_rd_local = rd_local;
        if (cfg_read) begin
            next_rd_local = cfg_image;
        end else if (cmp_read) begin
            next_rd_local = cmp_is_high ? cmp_sel[15:8] : cmp_sel[7:0];
        end else if (sfr_rd) begin
            next_rd_local = 8'h00; // see R11
        end
    end

    // Store byte or snapshot
    always @* begin
        next_rdata = sfr_rdata;
        if (rd_stage) begin
            next_rdata = rd_from_mem ? rl_rdata : rd_local;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_stage <= 1'b0;
            rd_from_mem <= 1'b0;
            rd_local <= 8'h00;
            sfr_rdata <= 8'h00;
            sfr_rvalid <= 1'b0;
        end else begin
            rd_stage <= sfr_rd;
            rd_from_mem <= rl_rd;
            rd_local <= next_rd_local;
            sfr_rvalid <= rd_stage;
            sfr_rdata <= next_rdata;
        end
    end

endmodule

// >>> dv/pcw_monitor.sv
// Port checker of the PWM cycle configuration block
// --------------------
// Checker
// --------------------
module pcw_monitor #(
    parameter NUM_MODULES = 6
) (
    input wire mclk,
    input wire reset,
    input wire [7:0] sfr_page,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire sfr_rvalid,
    input wire [15:0] array_main_counter,
    input wire [NUM_MODULES-1:0] pwm_mode_enable,
    input wire [NUM_MODULES-1:0] wide_pwm_select,
    input wire [NUM_MODULES-1:0] module_output_pin,
    input wire cycle_overflow_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire cfg_rd = sfr_rd && sfr_addr == 8'hD9 && sfr_page == 8'h0F;
    wire cfg_wr = sfr_wr && sfr_addr == 8'hD9 && sfr_page == 8'h0F;
    AST_RD_LATENCY: assert property (sfr_rd |-> ##2 sfr_rvalid)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (sfr_rvalid |-> $past(sfr_rd, 2))
        else $error("valid without read");
    AST_RSVD_ZERO: assert property (cfg_rd |-> ##2 (sfr_rdata[4:2] == 3'h0))
        else $error("unused bits not zero");
    AST_OFF_PAGE: assert property ((sfr_rd && sfr_addr == 8'hD9 && sfr_page != 8'h0F)
        |-> ##2 (sfr_rdata == 8'h00))
        else $error("config seen on wrong page");
    AST_MASK_OFF: assert property ((cfg_wr && !sfr_wdata[6]) |-> ##2 !cycle_overflow_irq)
        else $error("masked interrupt raised");
    AST_IRQ_RISE: assert property ($rose(cycle_overflow_irq) |->
        ($past(array_main_counter[7:0], 2) == 8'hFF && $past(array_main_counter[7:0]) == 8'h00)
        || $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("interrupt without cause");
    AST_IRQ_FALL: assert property ($fell(cycle_overflow_irq) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("flag cleared by hardware");
    AST_PIN_OFF: assert property (1'b1 |-> ((module_output_pin & ~$past(pwm_mode_enable)) == '0))
        else $error("disabled module drives pin");
    cover property (cfg_rd ##2 sfr_rvalid);
    cover property ($rose(cycle_overflow_irq));
    cover property ($rose(module_output_pin[0]));
endmodule
bind pcw_top pcw_monitor #(.NUM_MODULES(NUM_MODULES)) u_mon (
    .mclk(mclk), .reset(reset), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .array_main_counter(array_main_counter), .pwm_mode_enable(pwm_mode_enable),
    .wide_pwm_select(wide_pwm_select), .module_output_pin(module_output_pin),
    .cycle_overflow_irq(cycle_overflow_irq));

// >>> dv/pcw_top_tb.sv
// Testbench of the PWM cycle configuration block
module pcw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0;
    logic reset = 1;
    logic [7:0] pg = 0, ad = 0, wd = 0;
    logic wr_s = 0, rd_s = 0;
    logic [15:0] cnt = 0;
    logic [5:0] en = 0, wide = 0;
    wire [7:0] rdata;
    wire rvalid, irq;
    wire [5:0] pins;
    int num_errors = 0, comparisons = 0;
    always #4 mclk = ~mclk;
    pcw_top dut (
        .mclk(mclk),
        .reset(reset),
        .sfr_page(pg),
        .sfr_addr(ad),
        .sfr_wdata(wd),
        .sfr_wr(wr_s),
        .sfr_rd(rd_s),
        .sfr_rdata(rdata),
        .sfr_rvalid(rvalid),
        .array_main_counter(cnt),
        .pwm_mode_enable(en),
        .wide_pwm_select(wide),
        .module_output_pin(pins),
        .cycle_overflow_irq(irq)
    );
    // --------------------
    // Tasks
    // --------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        pg = p;
        ad = a;
        wd = d;
        wr_s = 1;
        @(negedge mclk);
        wr_s = 0;
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] exp);
        int i;
        @(negedge mclk);
        pg = p;
        ad = a;
        rd_s = 1;
        @(negedge mclk);
        rd_s = 0;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge mclk);
        check({7'h0, rvalid}, 8'h01);
        check(rdata, exp);
    endtask
    task automatic step(input logic [15:0] v);
        @(negedge mclk);
        cnt = v;
        repeat (2) @(negedge mclk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // --------------------
    // Tests
    // --------------------
    initial begin
        #100000;
        num_errors++;
        $display("[FAIL] %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        reset = 0;
        rd(8'h0F, 8'hD9, 8'h00);
        wr(8'h00, 8'hD9, 8'hFF);
        rd(8'h0F, 8'hD9, 8'h00);
        rd(8'h00, 8'hD9, 8'h00);
        wr(8'h0F, 8'hD9, 8'hFF);
        rd(8'h0F, 8'hD9, 8'hE3);
        check({7'h0, irq}, 8'h01);
        wr(8'h0F, 8'hD9, 8'h20);
        rd(8'h0F, 8'hD9, 8'h20);
        check({7'h0, irq}, 8'h00);
        wr(8'h0F, 8'hD9, 8'h00);
        rd(8'h0F, 8'hD9, 8'h00);
        $display("test registers done");
        for (int cl = 0; cl < 4; cl++) begin
            wr(8'h0F, 8'hD9, {6'h10, cl[1:0]});
            if (cl > 0) begin
                step(16'h00FF);
                step(16'h0100);
                rd(8'h0F, 8'hD9, {6'h10, cl[1:0]});
            end
            step(16'h07FF >> (3 - cl));
            step(16'h0100 << cl);
            rd(8'h0F, 8'hD9, {6'h18, cl[1:0]});
            check({7'h0, irq}, 8'h01);
        end
        $display("test overflow done");
        en = 6'h03;
        wide = 6'h02;
        wr(8'h0F, 8'hD9, 8'h00);
        wr(8'h00, 8'hE9, 8'h55);
        wr(8'h0F, 8'hD9, 8'h80);
        wr(8'h00, 8'hE9, 8'hAA);
        rd(8'h00, 8'hE9, 8'hAA);
        wr(8'h0F, 8'hD9, 8'h00);
        rd(8'h00, 8'hE9, 8'h55);
        wr(8'h00, 8'hFA, 8'h12);
        step(16'h00FF);
        step(16'h0100);
        rd(8'h00, 8'hE9, 8'h55);
        step(16'h0054);
        check({2'h0, pins}, 8'h00);
        step(16'h0056);
        check({2'h0, pins}, 8'h01);
        step(16'h1300);
        check({2'h0, pins}, 8'h02);
        $display("test pwm done");
        wr(8'h0F, 8'hD9, 8'h81);
        wr(8'h00, 8'hE9, 8'h10);
        wr(8'h0F, 8'hD9, 8'h01);
        step(16'h0020);
        check({2'h0, pins}, 8'h00);
        step(16'h01FF);
        step(16'h0200);
        step(16'h0220);
        check({2'h0, pins}, 8'h01);
        rd(8'h00, 8'hE9, 8'h10);
        $display("test reload done");
        wrap_up();
    end
endmodule
